//--- logic/clk_src_consts.svh
`ifndef CLK_SRC_CONSTS_SVH
`define CLK_SRC_CONSTS_SVH

// Strap codes that bypass the PLL multiplier
`define CLK_MODE_DIRECT 3'h3
`define CLK_MODE_PRESCALE 3'h1

// Watchdog disable flag position in the system configuration word
`define WDOG_DISABLE_BIT 4
`define SYS_CFG_WIDTH 16

// PLL clock cycles without an input transition before overflow
`define WDOG_OVERFLOW_CNT 5'h10
`define WDOG_CNT_WIDTH 5

// PLL settings per strap code: input divider, VCO multiplier, output divider, factor
`define PLL_CFG_CODE7 {3'h4, 7'h40, 3'h4, 5'h04}
`define PLL_CFG_CODE6 {3'h4, 7'h30, 3'h4, 5'h03}
`define PLL_CFG_CODE5 {3'h4, 7'h40, 3'h2, 5'h08}
`define PLL_CFG_CODE4 {3'h4, 7'h28, 3'h2, 5'h05}
`define PLL_CFG_CODE2 {3'h2, 7'h28, 3'h2, 5'h0A}
`define PLL_CFG_CODE0 {3'h2, 7'h40, 3'h2, 5'h10}
`define PLL_CFG_NONE {3'h0, 7'h00, 3'h0, 5'h00}

// Reset values
`define CPU_CLK_RESET 1'h0
`define COUNT_RESET 5'h00

`endif

//--- logic/clk_src_pkg.sv
package clk_src_pkg;

    typedef logic [2:0] strap_t;

    typedef enum logic [4:0] {
        ST_CAPTURE = 5'h01,
        ST_DIRECT = 5'h02,
        ST_PRESCALE = 5'h04,
        ST_PLL = 5'h08,
        ST_FAILOVER = 5'h10
    } clk_state_e;

    typedef struct packed {
        logic [2:0] in_div;
        logic [6:0] vco_mult;
        logic [2:0] out_div;
        logic [4:0] factor;
    } pll_cfg_s;

endpackage

//--- logic/owd_counter.sv
`timescale 1ns/10ps
`include "clk_src_consts.svh"

module osc_wdog_counter #(
    parameter int WIDTH = `WDOG_CNT_WIDTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Supervision control
    input wire logic enable_i,
    input wire logic tick_i,
    input wire logic clear_i,
    // Result
    output logic overflow_o
);
    logic [WIDTH-1:0] count_ff;
    logic overflow_ff;

    // Checked while elaborating, so a bad width never reaches simulation
    if (WIDTH < `WDOG_CNT_WIDTH) begin : g_width_check
        $error("osc_wdog_counter: WIDTH too small for overflow count");
    end

    // An input transition clears even when a tick lands in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_ff <= WIDTH'(`COUNT_RESET);
        end else if (!enable_i || clear_i) begin
            count_ff <= WIDTH'(`COUNT_RESET); // [RQ6]
        end else if (tick_i) begin
            if (count_ff == WIDTH'(`WDOG_OVERFLOW_CNT - 5'h01)) begin
                count_ff <= WIDTH'(`COUNT_RESET);
            end else begin
                count_ff <= count_ff + WIDTH'(1); // [RQ6]
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_ff <= 1'b0;
        end else begin
            overflow_ff <= enable_i && !clear_i && tick_i
                && count_ff == WIDTH'(`WDOG_OVERFLOW_CNT - 5'h01); // [RQ7]
        end
    end

    assign overflow_o = overflow_ff;

    overflow_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        overflow_o |-> $past(count_ff) == WIDTH'(`WDOG_OVERFLOW_CNT - 5'h01)
            && !$past(clear_i) && $past(tick_i))
        else $error("watchdog overflow without sixteen uncleared ticks");

    clear_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        clear_i |=> count_ff == WIDTH'(`COUNT_RESET) && !overflow_o)
        else $error("input transition did not clear the watchdog count");

endmodule

//--- logic/cpu_clock_source.sv
// Contract
// RQ1: Strap 011 disables PLL, bypasses oscillator amplifier, CPU clock follows input pin.
// RQ2: Direct drive: halves follow input duty, two halves make one input period.
// RQ3: Direct or prescale: PLL free-runs for watchdog unless disable bit set, then off.
// RQ4: Watchdog supervises only in direct drive and prescaler modes.
// RQ5: Watchdog enabled after reset; bit 4 of system configuration disables it.
// RQ6: Watchdog counter counts PLL cycles, clears on every input clock transition.
// RQ7: Overflow after 16 PLL cycles switches CPU clock to PLL, flags interrupt.
// RQ8: After switchover the clock stays on PLL until a reset.
// RQ9: Watchdog disabled: CPU clock from input, direct or prescaled, PLL off.
// RQ10: Other strap codes enable PLL, CPU clock is input times selected factor.
// RQ11: PLL mode resynchronises CPU clock to input on every F-th input transition.
// RQ12: Codes 111,110,101,100: input /4, VCO 64,48,64,40, output /4,4,2,2.
// RQ13: Codes 010 and 000: input /2, VCO 40 and 64, output /2.
// RQ14: Code 001 halves the input clock; watchdog and PLL power as direct drive.
// RQ15: Strap code latched at reset release, configuration fixed until next reset.
`timescale 1ns/10ps
`include "clk_src_consts.svh"

module cpu_clock_source #(
    parameter int CFG_WIDTH = `SYS_CFG_WIDTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Straps and input clock
    input wire clk_src_pkg::strap_t clock_mode_strap_pins_i,
    input wire logic clock_input_pin_i,
    // System configuration word
    input wire logic [CFG_WIDTH-1:0] system_config_register_i,
    // PLL timing strobes
    input wire logic pll_free_tick_i,
    input wire logic pll_vco_tick_i,
    // CPU clock and status
    output logic cpu_clk_o,
    output clk_src_pkg::clk_state_e clock_state_o,
    output logic wdog_irq_o,
    // PLL control
    output logic pll_power_o,
    output logic osc_amp_bypass_o,
    output logic pll_resync_o,
    output logic [2:0] pll_in_div_o,
    output logic [6:0] pll_vco_mult_o,
    output logic [2:0] pll_out_div_o
);
    import clk_src_pkg::*;

    // Checked while elaborating, so a narrow word is refused before any run
    if (CFG_WIDTH <= `WDOG_DISABLE_BIT) begin : g_cfg_width_check
        $error("cpu_clock_source: CFG_WIDTH must cover the disable bit");
    end

    function automatic pll_cfg_s pll_lookup(input strap_t code);
        pll_cfg_s cfg;
        cfg = `PLL_CFG_NONE;
        unique case (code)
            3'h7: cfg = `PLL_CFG_CODE7; // [RQ12]
            3'h6: cfg = `PLL_CFG_CODE6; // [RQ12]
            3'h5: cfg = `PLL_CFG_CODE5; // [RQ12]
            3'h4: cfg = `PLL_CFG_CODE4; // [RQ12]
            3'h2: cfg = `PLL_CFG_CODE2; // [RQ13]
            3'h0: cfg = `PLL_CFG_CODE0; // [RQ13]
            3'h3, 3'h1: cfg = `PLL_CFG_NONE;
        endcase
        return cfg;
    endfunction

    function automatic clk_state_e mode_of(input strap_t code);
        if (code == `CLK_MODE_DIRECT) begin
            return ST_DIRECT;
        end else if (code == `CLK_MODE_PRESCALE) begin
            return ST_PRESCALE;
        end
        return ST_PLL;
    endfunction

    clk_state_e state_ff;
    strap_t strap_ff;
    pll_cfg_s cfg_ff;
    logic xtal_prev_ff;
    logic cpu_clk_ff;
    logic irq_ff;
    logic power_ff;
    logic bypass_ff;
    logic resync_ff;
    logic [2:0] half_cnt_ff;
    logic [4:0] trans_cnt_ff;
    logic xtal_edge;
    logic xtal_rise;
    logic wdog_en;
    logic wdog_ovf;
    logic [2:0] half_len;

    assign xtal_edge = clock_input_pin_i ^ xtal_prev_ff;
    assign xtal_rise = clock_input_pin_i && !xtal_prev_ff;
    assign half_len = cfg_ff.out_div >> 1;

    // The disable flag is a live level; the configuration word resets to zero,
    // so supervision is on by default
    assign wdog_en = (state_ff == ST_DIRECT || state_ff == ST_PRESCALE)
        && !system_config_register_i[`WDOG_DISABLE_BIT]; // [RQ4] [RQ5]

    osc_wdog_counter #(
        .WIDTH(`WDOG_CNT_WIDTH)
    ) u_wdog_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(wdog_en),
        .tick_i(pll_free_tick_i),
        .clear_i(xtal_edge),
        .overflow_o(wdog_ovf)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            xtal_prev_ff <= 1'b0;
        end else begin
            xtal_prev_ff <= clock_input_pin_i;
        end
    end

    // Straps are taken in the first cycle after release, never under reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_ff <= 3'h0;
            cfg_ff <= `PLL_CFG_NONE;
        end else if (state_ff == ST_CAPTURE) begin
            strap_ff <= clock_mode_strap_pins_i; // [RQ15]
            cfg_ff <= pll_lookup(clock_mode_strap_pins_i); // [RQ12] [RQ13]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_CAPTURE;
        end else begin
            unique case (state_ff)
                ST_CAPTURE: state_ff <= mode_of(clock_mode_strap_pins_i); // [RQ15]
                ST_DIRECT, ST_PRESCALE: begin
                    if (wdog_ovf) begin
                        state_ff <= ST_FAILOVER; // [RQ7]
                    end
                end
                ST_PLL: state_ff <= ST_PLL;
                ST_FAILOVER: state_ff <= ST_FAILOVER; // [RQ8]
                default: state_ff <= ST_CAPTURE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_clk_ff <= `CPU_CLK_RESET;
        end else begin
            unique case (state_ff)
                ST_CAPTURE: cpu_clk_ff <= `CPU_CLK_RESET;
                // Fixed one-cycle delay keeps each pair of halves at one input period
                ST_DIRECT: cpu_clk_ff <= clock_input_pin_i; // [RQ1] [RQ2] [RQ9]
                ST_PRESCALE: begin
                    if (xtal_rise) begin
                        cpu_clk_ff <= !cpu_clk_ff; // [RQ14] [RQ9]
                    end
                end
                ST_PLL: begin
                    if (pll_vco_tick_i && half_cnt_ff == half_len - 3'h1) begin
                        cpu_clk_ff <= !cpu_clk_ff; // [RQ10]
                    end
                end
                ST_FAILOVER: begin
                    if (pll_free_tick_i) begin
                        cpu_clk_ff <= !cpu_clk_ff; // [RQ7] [RQ8]
                    end
                end
                default: cpu_clk_ff <= `CPU_CLK_RESET;
            endcase
        end
    end

    // VCO output divider: a toggle every half of the output divide ratio
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_cnt_ff <= 3'h0;
        end else if (state_ff != ST_PLL) begin
            half_cnt_ff <= 3'h0;
        end else if (pll_vco_tick_i) begin
            if (half_cnt_ff == half_len - 3'h1) begin
                half_cnt_ff <= 3'h0;
            end else begin
                half_cnt_ff <= half_cnt_ff + 3'h1; // [RQ10]
            end
        end
    end

    // The loop only gets a nudge each F-th transition, so frequency drifts smoothly
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trans_cnt_ff <= 5'h00;
            resync_ff <= 1'b0;
        end else if (state_ff == ST_PLL && xtal_edge) begin
            if (trans_cnt_ff == cfg_ff.factor - 5'h01) begin
                trans_cnt_ff <= 5'h00;
                resync_ff <= 1'b1; // [RQ11]
            end else begin
                trans_cnt_ff <= trans_cnt_ff + 5'h01;
                resync_ff <= 1'b0;
            end
        end else begin
            resync_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= wdog_en && wdog_ovf; // [RQ7]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_ff <= 1'b0;
            bypass_ff <= 1'b0;
        end else begin
            power_ff <= state_ff == ST_PLL || state_ff == ST_FAILOVER
                || wdog_en; // [RQ3] [RQ9] [RQ10] [RQ14]
            bypass_ff <= state_ff != ST_CAPTURE
                && strap_ff == `CLK_MODE_DIRECT; // [RQ1]
        end
    end

    assign cpu_clk_o = cpu_clk_ff;
    assign clock_state_o = state_ff;
    assign wdog_irq_o = irq_ff;
    assign pll_power_o = power_ff;
    assign osc_amp_bypass_o = bypass_ff;
    assign pll_resync_o = resync_ff;
    assign pll_in_div_o = cfg_ff.in_div;
    assign pll_vco_mult_o = cfg_ff.vco_mult;
    assign pll_out_div_o = cfg_ff.out_div;

    default clocking main_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence supervised_s;
        (state_ff == ST_DIRECT || state_ff == ST_PRESCALE)
            && !system_config_register_i[`WDOG_DISABLE_BIT];
    endsequence

    sequence overflow_s;
        supervised_s ##0 wdog_ovf;
    endsequence

    direct_follow_a: assert property ( // [RQ2]
        state_ff == ST_DIRECT ##1 state_ff == ST_DIRECT
            |-> cpu_clk_o == $past(clock_input_pin_i))
        else $error("direct drive clock does not follow the input pin");

    prescale_halve_a: assert property ( // [RQ14]
        state_ff == ST_PRESCALE && xtal_rise && !wdog_ovf |=> cpu_clk_o != $past(cpu_clk_o))
        else $error("prescaler did not toggle on input rising edge");

    switchover_a: assert property ( // [RQ7]
        overflow_s |=> state_ff == ST_FAILOVER && wdog_irq_o ##1 !wdog_irq_o)
        else $error("overflow did not switch clock and pulse the interrupt");

    failover_sticky_a: assert property ( // [RQ8]
        state_ff == ST_FAILOVER |=> state_ff == ST_FAILOVER [*2])
        else $error("clock left the free-running source without reset");

    wd_power_a: assert property ( // [RQ3]
        supervised_s ##1 supervised_s |-> pll_power_o)
        else $error("PLL not running for the watchdog");

    disabled_off_a: assert property ( // [RQ9]
        (state_ff == ST_DIRECT || state_ff == ST_PRESCALE)
            && system_config_register_i[`WDOG_DISABLE_BIT]
            |=> !pll_power_o && state_ff != ST_FAILOVER)
        else $error("PLL powered or switched while watchdog disabled");

    pll_mode_a: assert property ( // [RQ10]
        state_ff == ST_PLL ##1 state_ff == ST_PLL
            |-> pll_power_o && !osc_amp_bypass_o && !wdog_irq_o)
        else $error("PLL mode without PLL power");

    pll_nosuper_a: assert property ( // [RQ4]
        state_ff == ST_PLL |-> !wdog_en && !wdog_ovf)
        else $error("watchdog active in PLL mode");

    resync_only_pll_a: assert property ( // [RQ11]
        pll_resync_o |-> $past(state_ff) == ST_PLL && $past(xtal_edge))
        else $error("resync pulse outside PLL mode");

    table_a: assert property ( // [RQ12]
        state_ff == ST_PLL && strap_ff == 3'h4
            |-> pll_in_div_o == 3'h4 && pll_vco_mult_o == 7'h28 && pll_out_div_o == 3'h2)
        else $error("wrong PLL settings for code 100");

    table_x16_a: assert property ( // [RQ13]
        state_ff == ST_PLL && strap_ff == 3'h0
            |-> pll_in_div_o == 3'h2 && pll_vco_mult_o == 7'h40 && cfg_ff.factor == 5'h10)
        else $error("wrong PLL settings for code 000");

    strap_hold_a: assert property ( // [RQ15]
        state_ff != ST_CAPTURE |=> $stable(strap_ff) && state_ff != ST_CAPTURE)
        else $error("strap code changed after capture");

    bypass_a: assert property ( // [RQ1]
        state_ff == ST_DIRECT ##1 state_ff == ST_DIRECT |-> osc_amp_bypass_o)
        else $error("oscillator amplifier not bypassed in direct drive");

endmodule

//--- testbench/clk_src_model.sv
`timescale 1ns/10ps

// External clock source and free-running PLL; ticks stop when unpowered
module clk_src_model (
    // Clock
    input wire logic clk_i,
    // Bench control
    input wire logic run_i,
    input wire logic [3:0] half_i,
    input wire logic pll_power_i,
    // Toward the block
    output logic clock_input_pin_o,
    output logic pll_free_tick_o,
    output logic pll_vco_tick_o
);
    logic [3:0] cnt_ff;
    logic phase_ff;
    initial begin
        clock_input_pin_o = 1'b0;
        cnt_ff = 4'h0;
        phase_ff = 1'b0;
    end
    // A failed oscillator simply stops at its last level
    always @(posedge clk_i) begin
        if (run_i) begin
            if (cnt_ff >= half_i - 4'h1) begin
                cnt_ff <= 4'h0;
                clock_input_pin_o <= ~clock_input_pin_o;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
        phase_ff <= ~phase_ff;
    end
    assign pll_free_tick_o = pll_power_i & phase_ff;
    assign pll_vco_tick_o = pll_power_i & ~phase_ff;
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps

module tb;
    import clk_src_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    strap_t strap = 3'h7;
    logic [15:0] cfg = 16'h0000;
    logic run = 1'b1;
    logic [3:0] half = 4'h4;
    logic pin, ftick, vtick, cpu, irq, pwr, byp, rsync;
    clk_state_e st;
    logic [2:0] ind, outd;
    logic [6:0] vco;
    int fail_count = 0;
    int compares = 0;
    int irqs = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irqs++;

    clk_src_model model (.clk_i(clk), .run_i(run), .half_i(half), .pll_power_i(pwr),
        .clock_input_pin_o(pin), .pll_free_tick_o(ftick), .pll_vco_tick_o(vtick));

    cpu_clock_source dut (.clk_i(clk), .rst_i(rst), .clock_mode_strap_pins_i(strap),
        .clock_input_pin_i(pin), .system_config_register_i(cfg),
        .pll_free_tick_i(ftick), .pll_vco_tick_i(vtick), .cpu_clk_o(cpu),
        .clock_state_o(st), .wdog_irq_o(irq), .pll_power_o(pwr),
        .osc_amp_bypass_o(byp), .pll_resync_o(rsync), .pll_in_div_o(ind),
        .pll_vco_mult_o(vco), .pll_out_div_o(outd));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic do_reset(input strap_t s, input logic [15:0] c);
        rst = 1'b1;
        strap = s;
        cfg = c;
        tick(4);
        rst = 1'b0;
        tick(3);
    endtask

    task automatic test_direct();
        logic prev;
        half = 4'h7;
        do_reset(3'h3, 16'h0000);
        check("state", st, ST_DIRECT);
        check("bypass", byp, 1'b1);
        check("power", pwr, 1'b1);
        check("settings", {ind, vco, outd}, 13'h0);
        // Strap moves after capture must not reach the mode
        strap = 3'h7;
        prev = pin;
        repeat (40) begin
            tick(1);
            check("cpu_follow", cpu, prev);
            prev = pin;
        end
        check("state_kept", st, ST_DIRECT);
        half = 4'h4;
        $display("test direct done");
    endtask

    task automatic test_disabled();
        int i0;
        do_reset(3'h3, 16'h0010);
        check("power_off", pwr, 1'b0);
        i0 = irqs;
        run = 1'b0;
        tick(80);
        check("no_failover", st, ST_DIRECT);
        check("no_irq", irqs - i0, 0);
        check("cpu_is_pin", cpu, pin);
        run = 1'b1;
        $display("test disabled done");
    endtask

    task automatic test_prescale();
        int tog, rise;
        logic pc, pp;
        do_reset(3'h1, 16'h0000);
        check("state", st, ST_PRESCALE);
        check("bypass", byp, 1'b0);
        check("power", pwr, 1'b1);
        check("settings", {ind, vco, outd}, 13'h0);
        tog = 0;
        rise = 0;
        pc = cpu;
        pp = pin;
        repeat (80) begin
            tick(1);
            if (cpu !== pc) tog++;
            if (pin === 1'b1 && pp === 1'b0) rise++;
            pc = cpu;
            pp = pin;
        end
        check("half_rate", (tog >= rise - 1) && (tog <= rise + 1), 1'b1);
        $display("test prescale done");
    endtask

    task automatic test_failover();
        int n, tog, i0;
        logic pc;
        do_reset(3'h3, 16'h0000);
        tick(8);
        i0 = irqs;
        run = 1'b0;
        n = 0;
        while (st !== ST_FAILOVER && n < 80) begin
            tick(1);
            n++;
        end
        check("switch_time", (n >= 30) && (n <= 40), 1'b1);
        check("irq_pulse", irq, 1'b1);
        tick(1);
        check("irq_once", irq, 1'b0);
        check("irq_count", irqs - i0, 1);
        tog = 0;
        pc = cpu;
        repeat (20) begin
            tick(1);
            if (cpu !== pc) tog++;
            pc = cpu;
        end
        check("free_clock", (tog >= 9) && (tog <= 11), 1'b1);
        run = 1'b1;
        tick(40);
        check("stays", st, ST_FAILOVER);
        do_reset(3'h3, 16'h0000);
        check("restored", st, ST_DIRECT);
        $display("test failover done");
    endtask

    task automatic test_pll();
        strap_t codes[6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
        logic [17:0] exp[6] = '{{3'h4, 7'h40, 3'h4, 5'h04}, {3'h4, 7'h30, 3'h4, 5'h03},
            {3'h4, 7'h40, 3'h2, 5'h08}, {3'h4, 7'h28, 3'h2, 5'h05},
            {3'h2, 7'h28, 3'h2, 5'h0A}, {3'h2, 7'h40, 3'h2, 5'h10}};
        int n, tr, i0, tog;
        logic pp, pc;
        for (int k = 0; k < 6; k++) begin
            do_reset(codes[k], 16'h0000);
            check("state", st, ST_PLL);
            check("settings", {ind, vco, outd}, exp[k][17:5]);
            check("power", {pwr, byp}, 2'b10);
            // Twenty VCO ticks in forty cycles, one toggle per half the output divide
            tog = 0;
            pc = cpu;
            repeat (40) begin
                tick(1);
                if (cpu !== pc) tog++;
                pc = cpu;
            end
            check("cpu_rate", tog, 40 / exp[k][7:5]);
            n = 0;
            while (rsync !== 1'b1 && n < 200) begin
                tick(1);
                n++;
            end
            tr = 0;
            pp = pin;
            n = 0;
            do begin
                tick(1);
                n++;
                if (pin !== pp) tr++;
                pp = pin;
            end while (rsync !== 1'b1 && n < 300);
            check("resync_span", tr, {27'h0, exp[k][4:0]});
            i0 = irqs;
            run = 1'b0;
            tick(60);
            check("no_watch", {st === ST_PLL, irqs == i0}, 2'b11);
            run = 1'b1;
        end
        $display("test pll done");
    endtask

    task automatic complete_run();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        tick(1);
        test_direct();
        test_disabled();
        test_prescale();
        test_failover();
        test_pll();
        complete_run();
    end

    // The whole sequence needs about 1300 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("FAIL watchdog expected done seen hang");
        complete_run();
    end
endmodule
